/* File: src/dvt_pkg.sv */
package dvt_pkg;

  localparam int unsigned DVT_AW = 20;

  // register byte addresses
  localparam logic [19:0] DVT_OFS_VERTICAL_TOTAL = 20'h6000c;
  localparam logic [19:0] DVT_OFS_VBLANK = 20'h60010;
  localparam logic [19:0] DVT_OFS_VSYNC  = 20'h60014;
  localparam logic [19:0] DVT_OFS_SRC    = 20'h6001c;
  localparam logic [19:0] DVT_OFS_BORDER = 20'h60020;
  localparam logic [19:0] DVT_OFS_SHIFT  = 20'h60028;
  localparam logic [19:0] DVT_OFS_CTRL   = 20'h60030;
  localparam logic [19:0] DVT_OFS_STATUS = 20'h60034;

  // field positions
  localparam int unsigned DVT_HI_LSB  = 16;
  localparam int unsigned DVT_CLR_R   = 16;
  localparam int unsigned DVT_CLR_G   = 8;
  localparam int unsigned DVT_CLR_B   = 0;

  // writable bit masks
  localparam logic [31:0] DVT_MSK_VERTICAL_TOTAL = 32'h1fff0fff;
  localparam logic [31:0] DVT_MSK_WIN    = 32'h1fff1fff;
  localparam logic [31:0] DVT_MSK_SRC    = 32'h0fff0fff;
  localparam logic [31:0] DVT_MSK_BORDER = 32'h00ffffff;
  localparam logic [31:0] DVT_MSK_SHIFT  = 32'h00001fff;
  localparam logic [31:0] DVT_MSK_CTRL   = 32'h1fff0007;

  localparam logic [31:0] DVT_RST_REG    = 32'h00000000;

  // control bits
  localparam int unsigned DVT_CTL_EN     = 0;
  localparam int unsigned DVT_CTL_ILACE  = 1;
  localparam int unsigned DVT_CTL_SHIFT  = 2;

  localparam logic [1:0] DVT_RESP_OKAY   = 2'b00;
  localparam logic [1:0] DVT_RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
  } dvt_pixel_t;

  typedef struct packed {
    logic       vactive;
    logic       vborder;
    logic       vblank;
    logic       vsync;
    logic       field2;
    logic       frame_start;
  } dvt_vflags_t;

  typedef enum logic [2:0] {
    DVT_WR_IDLE = 3'b001,
    DVT_WR_RESP = 3'b010,
    DVT_WR_HOLD = 3'b100
  } dvt_wr_state_t;

endpackage : dvt_pkg

/* File: src/dvt_vtiming.sv */
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
// What this block does
// - vertical total, bits 28:16, minus one
// - line counter steps on hsync leading edge
// - interlace halves total and active per field
// - vertical active, bits 11:0, minus one
// - blank end, 28:16, line zero first active
// - interlace halves blank start and end
// - sync end 28:16, sync start 12:0
// - interlace halves sync start and end
// - horizontal source size 27:16, doubled multiply
// - only source size, border colour and control writable while enabled
// - vertical source size 11:0, multiply doubles
// - interlace halves vertical source size
// - border region outputs programmed border colour
// - shift used only in shift interlace mode
// - shift applied only in second field
module dvt_vtiming #(
  parameter int unsigned LINE_W = 13
) (
  input  wire logic                        core_clk,
  input  wire logic                        resetn,
  input  wire logic [dvt_pkg::DVT_AW-1:0]  s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  input  wire logic [dvt_pkg::DVT_AW-1:0]  s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic [31:0]                      s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  input  wire logic                        hsync_in,
  input  wire logic [12:0]                 hpos_in,
  input  wire logic                        hactive_in,
  input  wire logic                        pixel_multiply,
  input  wire dvt_pkg::dvt_pixel_t         plane_pixel,
  output dvt_pkg::dvt_pixel_t              pixel_out,
  output dvt_pkg::dvt_vflags_t             vflags_ff,
  output logic [LINE_W-1:0]                vline_ff,
  output logic [12:0]                      src_width_ff,
  output logic [12:0]                      src_lines_ff
);
  import dvt_pkg::*;

  logic [31:0]       vertical_total_ff;
  logic [31:0]       vblank_ff;
  logic [31:0]       vsync_ff;
  logic [31:0]       src_ff;
  logic [31:0]       border_ff;
  logic [31:0]       shift_ff;
  logic [31:0]       ctrl_ff;
  dvt_wr_state_t     wr_state_ff;
  logic              aw_got_ff;
  logic              w_got_ff;
  logic [DVT_AW-1:0] awaddr_ff;
  logic [31:0]       wdata_ff;
  logic [3:0]        wstrb_ff;
  logic              hs_meta_ff;
  logic              hs_sync_ff;
  logic              hs_prev_ff;
  logic [12:0]       hpos_meta_ff;
  logic [12:0]       hpos_ff;
  logic              field2_ff;
  logic              vs_pend_ff;
  logic [12:0]       shift_pos;
  logic              hs_rise;
  logic              ilace;
  logic [12:0]       f_total;
  logic [12:0]       f_active;
  logic [12:0]       f_bstart;
  logic [12:0]       f_bend;
  logic [12:0]       f_sstart;
  logic [12:0]       f_send;
  logic [LINE_W-1:0] nxt_vline;
  logic              in_active;
  logic              in_blank;
  logic              in_sync;

  // per-field value: interlace halves the programmed value
  function automatic logic [12:0] dvt_field(input logic [12:0] v, input logic il);
    dvt_field = il ? {1'b0, v[12:1]} : v;
  endfunction : dvt_field

  function automatic logic [31:0] dvt_merge(input logic [31:0] old, input logic [31:0] d,
                                            input logic [3:0] be, input logic [31:0] msk);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    dvt_merge = r & msk;
  endfunction : dvt_merge

  // write path: address and data accepted in either order
  // readies stay low while a response waits, so one write at most is in flight
  wire logic aw_take = s_axi_awvalid && s_axi_awready;
  wire logic w_take  = s_axi_wvalid && s_axi_wready;
  wire logic aw_have = aw_got_ff || aw_take;
  wire logic w_have  = w_got_ff || w_take;
  wire logic [DVT_AW-1:0] wa = aw_got_ff ? awaddr_ff : s_axi_awaddr;
  wire logic [31:0] wd = w_got_ff ? wdata_ff : s_axi_wdata;
  wire logic [3:0]  wb = w_got_ff ? wstrb_ff : s_axi_wstrb;
  wire logic do_wr = (wr_state_ff == DVT_WR_IDLE) && aw_have && w_have;
  wire logic pipe_en = ctrl_ff[DVT_CTL_EN];

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      wr_state_ff   <= DVT_WR_IDLE;
      aw_got_ff     <= 1'b0;
      w_got_ff      <= 1'b0;
      awaddr_ff     <= '0;
      wdata_ff      <= '0;
      wstrb_ff      <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= DVT_RESP_OKAY;
    end else begin
      case (wr_state_ff)
        DVT_WR_IDLE: begin
          if (aw_take) begin
            aw_got_ff <= 1'b1;
            awaddr_ff <= s_axi_awaddr;
          end
          if (w_take) begin
            w_got_ff <= 1'b1;
            wdata_ff <= s_axi_wdata;
            wstrb_ff <= s_axi_wstrb;
          end
          s_axi_awready <= !aw_have;
          s_axi_wready  <= !w_have;
          if (do_wr) begin
            aw_got_ff     <= 1'b0;
            w_got_ff      <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b1;
            wr_state_ff   <= DVT_WR_RESP;
            case (wa)
              DVT_OFS_VERTICAL_TOTAL, DVT_OFS_VBLANK, DVT_OFS_VSYNC, DVT_OFS_SRC, DVT_OFS_BORDER,
              DVT_OFS_SHIFT, DVT_OFS_CTRL, DVT_OFS_STATUS: s_axi_bresp <= DVT_RESP_OKAY;
              default: s_axi_bresp <= DVT_RESP_SLVERR;
            endcase
          end
        end
        DVT_WR_RESP: begin
          if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            wr_state_ff  <= DVT_WR_HOLD;
          end
        end
        DVT_WR_HOLD: begin
          s_axi_awready <= 1'b1;
          s_axi_wready  <= 1'b1;
          wr_state_ff   <= DVT_WR_IDLE;
        end
        default: wr_state_ff <= DVT_WR_IDLE;
      endcase
    end
  end

  // register store; timing words are locked while the pipe runs
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      vertical_total_ff <= DVT_RST_REG;
      vblank_ff <= DVT_RST_REG;
      vsync_ff  <= DVT_RST_REG;
      src_ff    <= DVT_RST_REG;
      border_ff <= DVT_RST_REG;
      shift_ff  <= DVT_RST_REG;
      ctrl_ff   <= DVT_RST_REG;
    end else if (do_wr) begin
      case (wa)
        DVT_OFS_VERTICAL_TOTAL: if (!pipe_en) vertical_total_ff <= dvt_merge(vertical_total_ff, wd, wb, DVT_MSK_VERTICAL_TOTAL);
        DVT_OFS_VBLANK: if (!pipe_en) vblank_ff <= dvt_merge(vblank_ff, wd, wb, DVT_MSK_WIN);
        DVT_OFS_VSYNC:  if (!pipe_en) vsync_ff  <= dvt_merge(vsync_ff, wd, wb, DVT_MSK_WIN);
        DVT_OFS_SHIFT:  if (!pipe_en) shift_ff  <= dvt_merge(shift_ff, wd, wb, DVT_MSK_SHIFT);
        DVT_OFS_SRC:    src_ff    <= dvt_merge(src_ff, wd, wb, DVT_MSK_SRC);
        DVT_OFS_BORDER: border_ff <= dvt_merge(border_ff, wd, wb, DVT_MSK_BORDER);
        DVT_OFS_CTRL:   ctrl_ff   <= dvt_merge(ctrl_ff, wd, wb, DVT_MSK_CTRL);
        default: ;
      endcase
    end
  end

  // read path: one word per request, answer one cycle after acceptance
  // unmapped reads answer zero with an error response
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= DVT_RESP_OKAY;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= DVT_RESP_OKAY;
      case (s_axi_araddr)
        DVT_OFS_VERTICAL_TOTAL: s_axi_rdata <= vertical_total_ff;
        DVT_OFS_VBLANK: s_axi_rdata <= vblank_ff;
        DVT_OFS_VSYNC:  s_axi_rdata <= vsync_ff;
        DVT_OFS_SRC:    s_axi_rdata <= src_ff;
        DVT_OFS_BORDER: s_axi_rdata <= border_ff;
        DVT_OFS_SHIFT:  s_axi_rdata <= shift_ff;
        DVT_OFS_CTRL:   s_axi_rdata <= ctrl_ff;
        DVT_OFS_STATUS: s_axi_rdata <= {7'h00, vflags_ff, 6'h00, 13'(vline_ff)};
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= DVT_RESP_SLVERR;
        end
      endcase
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

  // hsync and pixel position come from the horizontal pixel domain edge
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      hs_meta_ff   <= 1'b0;
      hs_sync_ff   <= 1'b0;
      hs_prev_ff   <= 1'b0;
      hpos_meta_ff <= '0;
      hpos_ff      <= '0;
    end else begin
      hs_meta_ff   <= hsync_in;
      hs_sync_ff   <= hs_meta_ff;
      hs_prev_ff   <= hs_sync_ff;
      hpos_meta_ff <= hpos_in;
      hpos_ff      <= hpos_meta_ff;
    end
  end

  assign ilace = ctrl_ff[DVT_CTL_ILACE];
  // the edge is taken after the synchroniser, so lines step three clocks late
  // leading edge of hsync
  assign hs_rise = hs_sync_ff && !hs_prev_ff;

  always_comb begin
    f_total  = dvt_field(vertical_total_ff[28:16], ilace);
    f_active = dvt_field({1'b0, vertical_total_ff[11:0]}, ilace);
    f_bstart = dvt_field(vblank_ff[12:0], ilace);
    f_bend   = dvt_field(vblank_ff[28:16], ilace);
    f_sstart = dvt_field(vsync_ff[12:0], ilace);
    f_send   = dvt_field(vsync_ff[28:16], ilace);
    if (13'(vline_ff) >= f_total) begin
      nxt_vline = '0;
    end else begin
      nxt_vline = vline_ff + 1'b1;
    end
  end

  // control word: enable, interlace, shift mode, horizontal total minus one
  // shift register or half htotal
  assign shift_pos = (ilace && ctrl_ff[DVT_CTL_SHIFT]) ? shift_ff[12:0] : {1'b0, ctrl_ff[28:17]};

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      vline_ff  <= '0;
      field2_ff <= 1'b0;
    end else if (!pipe_en) begin
      vline_ff  <= '0;
      field2_ff <= 1'b0;
    end else if (hs_rise) begin
      vline_ff <= nxt_vline;
      // field two toggles only on the wrap, and only when interlaced
      if (13'(vline_ff) >= f_total) begin
        field2_ff <= ilace && !field2_ff;
      end
    end
  end

  // blank window runs start+1 .. end, with no wrap, so it is empty when start is not below end
  assign in_active = 13'(vline_ff) <= f_active;
  assign in_blank  = (13'(vline_ff) > f_bstart) && (13'(vline_ff) <= f_bend);
  assign in_sync   = (13'(vline_ff) > f_sstart) && (13'(vline_ff) <= f_send);

  // vsync edges line up with hsync, or with the shift point in field two
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      vflags_ff  <= '0;
      vs_pend_ff <= 1'b0;
    end else begin
      vflags_ff.vactive     <= pipe_en && in_active;
      vflags_ff.vblank      <= pipe_en && in_blank;
      vflags_ff.vborder     <= pipe_en && !in_active && !in_blank;
      vflags_ff.field2      <= field2_ff;
      vflags_ff.frame_start <= pipe_en && hs_rise && (13'(vline_ff) >= f_total);
      if (!pipe_en) begin
        vflags_ff.vsync <= 1'b0;
        vs_pend_ff      <= 1'b0;
      end else if (field2_ff) begin
        if (hs_rise) begin
          vs_pend_ff <= 1'b1;
        end else if (vs_pend_ff && hpos_ff == shift_pos) begin
          vs_pend_ff      <= 1'b0;
          vflags_ff.vsync <= in_sync;
        end
      end else if (hs_rise) begin
        // a shift point still pending from field two must not fire later
        vs_pend_ff      <= 1'b0;
        vflags_ff.vsync <= (nxt_vline > LINE_W'(f_sstart)) && (nxt_vline <= LINE_W'(f_send));
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      pixel_out <= '0;
    end else if (!pipe_en || in_blank) begin
      pixel_out <= '0;
    end else if (in_active && hactive_in) begin
      pixel_out <= plane_pixel;
    end else begin
      pixel_out.red   <= border_ff[DVT_CLR_R +: 8];
      pixel_out.green <= border_ff[DVT_CLR_G +: 8];
      pixel_out.blue  <= border_ff[DVT_CLR_B +: 8];
    end
  end

  // real source size handed to the blender
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      src_width_ff <= '0;
      src_lines_ff <= '0;
    end else begin
      // a doubled 4096 does not fit 13 bits and reads as zero
      // width field, doubled
      src_width_ff <= pixel_multiply ? {src_ff[27:16] + 12'h001, 1'b0}
                                     : {1'b0, src_ff[27:16]} + 13'h0001;
      src_lines_ff <= dvt_field(pixel_multiply ? {src_ff[11:0] + 12'h001, 1'b0}
                                               : {1'b0, src_ff[11:0]} + 13'h0001, ilace);
    end
  end

endmodule : dvt_vtiming

/* File: tb/dvt_vt_monitor.sv */
`timescale 1ns/10ps
module dvt_vt_monitor #(
  parameter int unsigned LINE_W = 13
) (
  input wire logic                core_clk,
  input wire logic                resetn,
  input wire logic                s_axi_awready,
  input wire logic                s_axi_wready,
  input wire logic                s_axi_bvalid,
  input wire logic                s_axi_bready,
  input wire logic                s_axi_arready,
  input wire logic [31:0]         s_axi_rdata,
  input wire logic                s_axi_rvalid,
  input wire logic                s_axi_rready,
  input wire logic                pixel_multiply,
  input wire dvt_pkg::dvt_pixel_t  pixel_out,
  input wire dvt_pkg::dvt_vflags_t vflags_ff,
  input wire logic [LINE_W-1:0]   vline_ff,
  input wire logic [12:0]         src_width_ff
);
  import dvt_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data not held");
  wr_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  rd_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
  line_step_a: assert property (
    $changed(vline_ff) && vline_ff != 0 |-> vline_ff == $past(vline_ff) + 1'b1)
    else $error("line counter skipped");
  frame_pulse_a: assert property (
    vflags_ff.frame_start |=> !vflags_ff.frame_start) else $error("frame start too long");
  frame_line_a: assert property (
    vflags_ff.frame_start |-> vline_ff == 0) else $error("frame start off line zero");
  // one cycle of slack covers the pixel and flag registers settling together
  blank_black_a: assert property (
    vflags_ff.vblank && $past(vflags_ff.vblank) |-> pixel_out == '0)
    else $error("pixel not black in blank");
  even_width_a: assert property (
    pixel_multiply && $past(pixel_multiply) |-> !src_width_ff[0])
    else $error("multiplied width is odd");
endmodule : dvt_vt_monitor

bind dvt_vtiming dvt_vt_monitor #(.LINE_W(LINE_W)) u_mon (
  .core_clk(core_clk), .resetn(resetn), .s_axi_awready(s_axi_awready),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .pixel_multiply(pixel_multiply), .pixel_out(pixel_out),
  .vflags_ff(vflags_ff), .vline_ff(vline_ff), .src_width_ff(src_width_ff));

/* File: tb/dvt_hsrc_model.sv */
`timescale 1ns/10ps
module dvt_hsrc_model #(
  parameter int unsigned HLEN = 16
) (
  input wire logic            core_clk,
  input wire logic            resetn,
  output logic                hsync,
  output logic [12:0]         hpos,
  output logic                hact,
  output dvt_pkg::dvt_pixel_t pix
);
  import dvt_pkg::*;
  // short lines keep a whole frame within a few hundred cycles
  always_ff @(posedge core_clk) begin
    if (!resetn || hpos == 13'(HLEN - 1)) hpos <= 13'h0;
    else hpos <= hpos + 13'h1;
  end
  assign hsync = hpos < 13'h4;
  assign hact  = hpos >= 13'h6 && hpos < 13'he;
  assign pix   = 24'h123456;
endmodule : dvt_hsrc_model

/* File: tb/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
  import dvt_pkg::*;
  logic core_clk = 0, resetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
  logic rready = 0, pmul = 0, awready, wready, bvalid, arready, rvalid, hsync, hact;
  logic [19:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, d, mb, ms, mv, mo;
  logic [3:0]  wstrb = 0;
  logic [1:0]  bresp, rresp, r;
  logic [12:0] hpos, vline, sw, sl, maxl, ld;
  dvt_pixel_t  pix, pout;
  dvt_vflags_t vf;
  int err_total = 0, checked = 0, cyc = 0, badpx, f1, f0, h1, h2;
  logic pvb, pact, pvs;

  always #20 core_clk = ~core_clk;

  dvt_vtiming u_dut (.core_clk(core_clk), .resetn(resetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .hsync_in(hsync), .hpos_in(hpos), .hactive_in(hact),
    .pixel_multiply(pmul), .plane_pixel(pix), .pixel_out(pout), .vflags_ff(vf),
    .vline_ff(vline), .src_width_ff(sw), .src_lines_ff(sl));
  dvt_hsrc_model u_hsrc (.core_clk(core_clk), .resetn(resetn), .hsync(hsync),
    .hpos(hpos), .hact(hact), .pix(pix));

  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : conclude

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      conclude();
    end
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic wr(input logic [19:0] a, input logic [31:0] v, output logic [1:0] rs);
    bit ad, wd;
    ad = 0;
    wd = 0;
    @(posedge core_clk);
    awaddr <= a; awvalid <= 1; wdata <= v; wstrb <= 4'hf; wvalid <= 1;
    while (!(ad && wd)) begin
      @(posedge core_clk);
      if (!ad && awready) begin awvalid <= 0; ad = 1; end
      if (!wd && wready) begin wvalid <= 0; wd = 1; end
    end
    bready <= 1;
    do @(posedge core_clk); while (bvalid !== 1'b1);
    rs = bresp;
    bready <= 0;
  endtask : wr

  task automatic rd(input logic [19:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge core_clk);
    araddr <= a; arvalid <= 1;
    do @(posedge core_clk); while (arready !== 1'b1);
    arvalid <= 0; rready <= 1;
    do @(posedge core_clk); while (rvalid !== 1'b1);
    v = rdata; rs = rresp;
    rready <= 0;
  endtask : rd

  // flags lag the line by one cycle, so each flag is filed under the previous line;
  // field-one vsync steps together with the line, so it is filed under the line itself
  task automatic scan(input int n);
    mb = 0; ms = 0; mv = 0; mo = 0; maxl = 0; badpx = 0; f1 = 0; f0 = 0;
    ld = vline; pvb = 0; pact = 0; pvs = 0; h1 = 0; h2 = 0;
    repeat (n) begin
      @(posedge core_clk);
      if (vf.vblank) mb[ld[4:0]] = 1;
      if (vf.vsync && !vf.field2) ms[vline[4:0]] = 1;
      if (vf.vactive) mv[ld[4:0]] = 1;
      if (vf.vborder) mo[ld[4:0]] = 1;
      if (vline > maxl) maxl = vline;
      if (vf.field2) f1++; else f0++;
      if (pvb && vf.vborder && pact && hact && pout !== 24'ha1b2c3) badpx++;
      if (vf.vactive && pact && pout !== 24'h123456) badpx++;
      // pixel position at the first vsync cycle of each field, for the shift offset
      if (vf.vsync && !pvs && vf.field2) h2 = int'(hpos);
      if (vf.vsync && !pvs && !vf.field2) h1 = int'(hpos);
      pvb = vf.vborder; pact = hact; ld = vline; pvs = vf.vsync;
    end
  endtask : scan

  task automatic t_regs();
    logic [19:0] a[6];
    logic [31:0] m[6];
    a = '{DVT_OFS_VERTICAL_TOTAL, DVT_OFS_VBLANK, DVT_OFS_VSYNC, DVT_OFS_SRC, DVT_OFS_BORDER,
          DVT_OFS_SHIFT};
    m = '{DVT_MSK_VERTICAL_TOTAL, DVT_MSK_WIN, DVT_MSK_WIN, DVT_MSK_SRC, DVT_MSK_BORDER,
          DVT_MSK_SHIFT};
    for (int i = 0; i < 6; i++) begin
      rd(a[i], d, r);
      chk("reset value", 32'h0, d);
      wr(a[i], 32'hffffffff, r);
      rd(a[i], d, r);
      chk("field mask", m[i], d);
    end
    rd(20'h60040, d, r);
    chk("unmapped read", {30'h0, DVT_RESP_SLVERR}, {30'h0, r});
    wr(20'h60044, 32'h1, r);
    chk("unmapped write", {30'h0, DVT_RESP_SLVERR}, {30'h0, r});
    $display("test registers done");
  endtask : t_regs

  task automatic t_prog();
    wr(DVT_OFS_VERTICAL_TOTAL, 32'h00090003, r);
    wr(DVT_OFS_VBLANK, 32'h00080005, r);
    wr(DVT_OFS_VSYNC, 32'h00070006, r);
    wr(DVT_OFS_SRC, 32'h00090007, r);
    wr(DVT_OFS_BORDER, 32'h00a1b2c3, r);
    wr(DVT_OFS_CTRL, 32'h000f0001, r);
    scan(500);
    chk("last line", 32'd9, {19'h0, maxl});
    chk("active lines", 32'h00f, mv);
    chk("blank lines", 32'h1c0, mb);
    chk("sync lines", 32'h080, ms);
    chk("border lines", 32'h230, mo);
    chk("border pixels", 32'h0, badpx);
    chk("source size", {6'h0, 13'd10, 13'd8}, {6'h0, sw, sl});
    wr(DVT_OFS_VERTICAL_TOTAL, 32'h00050002, r);
    rd(DVT_OFS_VERTICAL_TOTAL, d, r);
    chk("locked total", 32'h00090003, d);
    wr(DVT_OFS_SRC, 32'h00050003, r);
    rd(DVT_OFS_SRC, d, r);
    chk("live source", 32'h00050003, d);
    $display("test progressive done");
  endtask : t_prog

  task automatic t_ilace();
    wr(DVT_OFS_CTRL, 32'h000f0000, r);
    wr(DVT_OFS_VERTICAL_TOTAL, 32'h00130007, r);
    wr(DVT_OFS_VBLANK, 32'h00100009, r);
    wr(DVT_OFS_VSYNC, 32'h000e000c, r);
    wr(DVT_OFS_SRC, 32'h00090007, r);
    wr(DVT_OFS_CTRL, 32'h000f0003, r);
    scan(700);
    chk("field last line", 32'd9, {19'h0, maxl});
    chk("field active", 32'h00f, mv);
    chk("field blank", 32'h1e0, mb);
    chk("field sync", 32'h080, ms);
    chk("both fields", 32'h1, {31'h0, f1 > 0 && f0 > 0});
    chk("field src lines", 32'd4, {19'h0, sl});
    chk("legacy shift", 32'd7, h2 - h1);
    chk("field pixels", 32'h0, badpx);
    pmul <= 1;
    repeat (4) @(posedge core_clk);
    chk("doubled width", 32'd20, {19'h0, sw});
    chk("doubled lines", 32'd8, {19'h0, sl});
    $display("test interlace done");
  endtask : t_ilace

  task automatic t_shift();
    wr(DVT_OFS_CTRL, 32'h000f0000, r);
    wr(DVT_OFS_VBLANK, 32'h00130007, r);
    // hsync at pixel 0 less half of a 16-pixel line, taken modulo the line
    wr(DVT_OFS_SHIFT, 32'h00000008, r);
    wr(DVT_OFS_CTRL, 32'h000f0007, r);
    scan(700);
    chk("no border", 32'h0, mo);
    chk("full blank", 32'h3f0, mb);
    chk("shift offset", 32'd8, h2 - h1);
    $display("test sync shift done");
  endtask : t_shift

  initial begin
    repeat (20) @(posedge core_clk);
    resetn <= 1;
    @(posedge core_clk);
    t_regs();
    t_prog();
    t_ilace();
    t_shift();
    conclude();
  end
endmodule : tb_top
